/* File: src/rbms_pkg.sv */
// constants for reset handling, boot-mode selection and the host serial link
// ---------------------------------------------------------------------------
// What this block does
// - All general pins float while reset is active.
// - At power-up the block pulls the shared reset line low itself.
// - Low boot-select or closed jumper during reset enters update mode.
// - Update mode carries firmware over the serial out and in pins.
// - Normal mode uses the same serial port for host tool traffic.
// - The host link runs 57600 baud, 8 data bits, no parity, 1 stop.
// - While running, every digital output is driven high and low.
// ---------------------------------------------------------------------------
package rbms_pkg;
  localparam int unsigned CLK_HZ       = 50_000_000;
  localparam int unsigned BAUD_RATE    = 57_600;
  localparam int unsigned BAUD_DIV     = CLK_HZ / BAUD_RATE;
  localparam int unsigned DATA_BITS    = 8;
  localparam int unsigned NUM_OUTS     = 8;
  localparam int unsigned EXT_RESET_MS = 50;
  localparam int unsigned POR_TIME_US  = 10_000;
  localparam int unsigned POR_CYC      = POR_TIME_US * (CLK_HZ / 1_000_000);
  localparam logic [7:0]  OUT_RESET    = 8'h00;

  typedef enum logic [1:0] {
    RBMS_POWER_UP  = 2'b00,
    RBMS_WAIT_HIGH = 2'b01,
    RBMS_RUN       = 2'b11
  } rbms_state_t;
endpackage : rbms_pkg

/* File: src/rbms_ser_if.sv */
// byte stream between the sequencer and its serial port
`timescale 1ns/1ps
interface rbms_ser_if;
  logic       enable;
  logic [7:0] tx_data;
  logic       tx_valid;
  logic       tx_ready;
  logic [7:0] rx_data;
  logic       rx_valid;

  modport ctrl (output enable, output tx_data, output tx_valid, input tx_ready,
                input rx_data, input rx_valid);
  modport port (input enable, input tx_data, input tx_valid, output tx_ready,
                output rx_data, output rx_valid);
endinterface : rbms_ser_if

/* File: src/rbms_uart.sv */
// fixed-format asynchronous serial port, 8 data bits, no parity, 1 stop bit
`timescale 1ns/1ps
module rbms_uart (
  // clock, reset and clock enable
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic en_i,
  // user side
  rbms_ser_if.port  ser,
  // line
  input  wire logic serial_in_i,
  output logic      serial_out_o
);
  localparam logic [9:0] DIV_LAST = 10'(rbms_pkg::BAUD_DIV - 1);
  localparam logic [9:0] DIV_HALF = 10'(rbms_pkg::BAUD_DIV / 2);

  // ---------------------------------------------------------------------------
  // transmitter
  // ---------------------------------------------------------------------------
  logic [9:0] tx_sh_q, tx_sh_d;
  logic [9:0] tx_div_q, tx_div_d;
  logic [3:0] tx_cnt_q, tx_cnt_d;
  logic       tx_busy_q, tx_busy_d;

  assign ser.tx_ready = ser.enable && !tx_busy_q;

  always_comb begin
    tx_sh_d   = tx_sh_q;
    tx_div_d  = tx_div_q;
    tx_cnt_d  = tx_cnt_q;
    tx_busy_d = tx_busy_q;
    if (!ser.enable) begin
      tx_sh_d   = 10'h3FF;
      tx_busy_d = 1'b0;
    end else if (!tx_busy_q) begin
      if (ser.tx_valid) begin
        tx_sh_d   = {1'b1, ser.tx_data, 1'b0};
        tx_div_d  = 10'h000;
        tx_cnt_d  = 4'h0;
        tx_busy_d = 1'b1;
      end
    end else if (tx_div_q == DIV_LAST) begin
      tx_div_d = 10'h000;
      tx_sh_d  = {1'b1, tx_sh_q[9:1]};
      tx_cnt_d = tx_cnt_q + 4'h1;
      if (tx_cnt_q == 4'h9) begin
        tx_busy_d = 1'b0;
      end
    end else begin
      tx_div_d = tx_div_q + 10'h001;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_sh_q   <= 10'h3FF;
      tx_div_q  <= 10'h000;
      tx_cnt_q  <= 4'h0;
      tx_busy_q <= 1'b0;
    end else if (en_i) begin
      tx_sh_q   <= tx_sh_d;
      tx_div_q  <= tx_div_d;
      tx_cnt_q  <= tx_cnt_d;
      tx_busy_q <= tx_busy_d;
    end
  end

  assign serial_out_o = tx_sh_q[0];

  // ---------------------------------------------------------------------------
  // receiver
  // ---------------------------------------------------------------------------
  logic       rx_s1_q, rx_s2_q;
  logic [8:0] rx_sh_q, rx_sh_d;
  logic [9:0] rx_div_q, rx_div_d;
  logic [3:0] rx_cnt_q, rx_cnt_d;
  logic       rx_busy_q, rx_busy_d;
  logic [7:0] rx_data_q, rx_data_d;
  logic       rx_vld_q, rx_vld_d;

  always_comb begin
    rx_sh_d   = rx_sh_q;
    rx_div_d  = rx_div_q;
    rx_cnt_d  = rx_cnt_q;
    rx_busy_d = rx_busy_q;
    rx_data_d = rx_data_q;
    rx_vld_d  = 1'b0;
    if (!ser.enable) begin
      rx_busy_d = 1'b0;
    end else if (!rx_busy_q) begin
      if (!rx_s2_q) begin
        rx_busy_d = 1'b1;
        rx_div_d  = DIV_HALF;
        rx_cnt_d  = 4'h0;
      end
    end else if (rx_div_q == DIV_LAST) begin
      rx_div_d = 10'h000;
      rx_cnt_d = rx_cnt_q + 4'h1;
      rx_sh_d  = {rx_s2_q, rx_sh_q[8:1]};
      if (rx_cnt_q == 4'h0 && rx_s2_q) begin
        rx_busy_d = 1'b0;                      // false start
      end else if (rx_cnt_q == 4'h9) begin
        rx_busy_d = 1'b0;
        if (rx_s2_q) begin
          rx_data_d = rx_sh_q[8:1];
          rx_vld_d  = 1'b1;
        end
      end
    end else begin
      rx_div_d = rx_div_q + 10'h001;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_s1_q   <= 1'b1;
      rx_s2_q   <= 1'b1;
      rx_sh_q   <= 9'h000;
      rx_div_q  <= 10'h000;
      rx_cnt_q  <= 4'h0;
      rx_busy_q <= 1'b0;
      rx_data_q <= 8'h00;
      rx_vld_q  <= 1'b0;
    end else if (en_i) begin
      rx_s1_q   <= serial_in_i;
      rx_s2_q   <= rx_s1_q;
      rx_sh_q   <= rx_sh_d;
      rx_div_q  <= rx_div_d;
      rx_cnt_q  <= rx_cnt_d;
      rx_busy_q <= rx_busy_d;
      rx_data_q <= rx_data_d;
      rx_vld_q  <= rx_vld_d;
    end
  end

  assign ser.rx_data  = rx_data_q;
  assign ser.rx_valid = rx_vld_q && en_i;

  a_tx_start_bit: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    en_i && ser.tx_valid && ser.tx_ready |=> !serial_out_o)
    else $error("start bit not low");
  a_tx_stop_bit: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    en_i && tx_busy_q && tx_cnt_q == 4'h9 |-> serial_out_o)
    else $error("stop bit not high");
  a_idle_high: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !tx_busy_q |-> serial_out_o)
    else $error("line not idle high");
  a_tx_bit_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    en_i && ser.enable && tx_busy_q && tx_div_q != DIV_LAST |=> $stable(serial_out_o))
    else $error("bit changed inside its period");
  a_rx_pulse_once: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    en_i && rx_vld_q |=> !rx_vld_q)
    else $error("receive pulse longer than one cycle");
  a_rx_data_held: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !rx_vld_q |-> $stable(rx_data_q))
    else $error("received byte changed without pulse");
endmodule : rbms_uart

/* File: src/rbms_top.sv */
// reset sequencer, boot-mode selection and pin control with host serial port
`timescale 1ns/1ps
module rbms_top #(
  parameter int unsigned POR_CYCLES = rbms_pkg::POR_CYC
) (
  // clock, power-on reset, clock enable
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       en_i,
  // shared open-drain reset line
  input  wire logic       reset_line_n_i,
  output logic            reset_line_n_o,
  output logic            reset_line_n_oe_o,
  // boot straps
  input  wire logic       boot_select_n_i,
  input  wire logic       update_jumper_i,
  // digital outputs
  input  wire logic [7:0] app_out_i,
  output logic      [7:0] digital_output_o,
  output logic      [7:0] digital_output_oe_o,
  // serial pins
  input  wire logic       serial_in_i,
  output logic            serial_out_o,
  output logic            serial_out_oe_o,
  // host byte stream
  input  wire logic [7:0] tx_data_i,
  input  wire logic       tx_valid_i,
  output logic            tx_ready_o,
  output logic      [7:0] rx_data_o,
  output logic            rx_valid_o,
  // status
  output logic            running_o,
  output logic            boot_mode_o
);
  // ---------------------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------------------
  // line and straps are level inputs: two flops each before any decision reads them
  logic line_s1_q, line_s2_q, boot_s1_q, boot_s2_q, jmp_s1_q, jmp_s2_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      line_s1_q <= 1'b0;
      line_s2_q <= 1'b0;
      boot_s1_q <= 1'b1;
      boot_s2_q <= 1'b1;
      jmp_s1_q  <= 1'b0;
      jmp_s2_q  <= 1'b0;
    end else if (en_i) begin
      line_s1_q <= reset_line_n_i;
      line_s2_q <= line_s1_q;
      boot_s1_q <= boot_select_n_i;
      boot_s2_q <= boot_s1_q;
      jmp_s1_q  <= update_jumper_i;
      jmp_s2_q  <= jmp_s1_q;
    end
  end

  // ---------------------------------------------------------------------------
  // reset sequencer
  // ---------------------------------------------------------------------------
  rbms_pkg::rbms_state_t state_q, state_d;
  logic [31:0]           por_cnt_q, por_cnt_d;
  logic                  mode_q, mode_d;
  logic                  running;

  always_comb begin
    state_d   = state_q;
    por_cnt_d = por_cnt_q;
    mode_d    = mode_q;
    unique case (state_q)
      rbms_pkg::RBMS_POWER_UP: begin
        por_cnt_d = por_cnt_q + 32'h1;
        if (por_cnt_q == 32'(POR_CYCLES - 1)) begin
          state_d = rbms_pkg::RBMS_WAIT_HIGH;
        end
      end
      rbms_pkg::RBMS_WAIT_HIGH: begin
        // straps are taken once, on the way into run, and ignored after that
        if (line_s2_q) begin
          state_d = rbms_pkg::RBMS_RUN;
          mode_d  = !boot_s2_q || jmp_s2_q;
        end
      end
      rbms_pkg::RBMS_RUN: begin
        // no length filter: any low the synchroniser sees leaves run
        if (!line_s2_q) begin
          state_d = rbms_pkg::RBMS_WAIT_HIGH;
        end
      end
      default: begin
        state_d = rbms_pkg::RBMS_POWER_UP;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q   <= rbms_pkg::RBMS_POWER_UP;
      por_cnt_q <= 32'h0;
      mode_q    <= 1'b0;
    end else if (en_i) begin
      state_q   <= state_d;
      por_cnt_q <= por_cnt_d;
      mode_q    <= mode_d;
    end
  end

  assign running           = state_q == rbms_pkg::RBMS_RUN;
  assign running_o         = running;
  assign boot_mode_o       = mode_q;
  // only ever pulls low; the line rises through the outside pull-up
  assign reset_line_n_o    = 1'b0;
  assign reset_line_n_oe_o = state_q == rbms_pkg::RBMS_POWER_UP;

  // ---------------------------------------------------------------------------
  // digital outputs
  // ---------------------------------------------------------------------------
  logic [7:0] out_q, out_d;

  always_comb begin
    // zero off run, so no stale value shows when the pins drive again
    out_d = running ? app_out_i : rbms_pkg::OUT_RESET;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_q <= rbms_pkg::OUT_RESET;
    end else if (en_i) begin
      out_q <= out_d;
    end
  end

  assign digital_output_o    = out_q;
  assign digital_output_oe_o = {rbms_pkg::NUM_OUTS{running}};
  assign serial_out_oe_o     = running;

  // ---------------------------------------------------------------------------
  // host serial port, shared by both modes
  // ---------------------------------------------------------------------------
  // the link is the same in both modes; the mode is only reported outward
  rbms_ser_if ser ();

  assign ser.enable   = running;
  assign ser.tx_data  = tx_data_i;
  assign ser.tx_valid = tx_valid_i;
  assign tx_ready_o   = ser.tx_ready && en_i;
  assign rx_data_o    = ser.rx_data;
  assign rx_valid_o   = ser.rx_valid;

  rbms_uart u_uart (
    .clk_i        (clk_i),
    .rst_n_i      (rst_n_i),
    .en_i         (en_i),
    .ser          (ser.port),
    .serial_in_i  (serial_in_i),
    .serial_out_o (serial_out_o)
  );

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  a_pins_float_reset: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !running |-> digital_output_oe_o == 8'h00 && !serial_out_oe_o)
    else $error("pins driven during reset");
  a_line_held_powerup: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    state_q == rbms_pkg::RBMS_POWER_UP |-> reset_line_n_oe_o && !reset_line_n_o)
    else $error("reset line not pulled low at power-up");
  a_line_release: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $fell(reset_line_n_oe_o) |-> $past(por_cnt_q) == 32'(POR_CYCLES - 1))
    else $error("reset line released at wrong time");
  a_mode_pick: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(running) |-> mode_q == (!$past(boot_s2_q) || $past(jmp_s2_q)))
    else $error("boot mode not taken from straps");
  a_mode_kept: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    running && $past(running) |-> $stable(mode_q))
    else $error("boot mode changed while running");
  a_ext_reset_seen: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    en_i && running && !line_s2_q |=> !running)
    else $error("external reset not honoured");
  a_outs_follow: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    en_i && running && line_s2_q |=>
    digital_output_o == $past(app_out_i) && digital_output_oe_o == 8'hFF)
    else $error("outputs not driven from application");
  a_port_gated: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !running |-> !tx_ready_o)
    else $error("serial port open during reset");

  a_line_only_powerup: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    state_q != rbms_pkg::RBMS_POWER_UP |-> !reset_line_n_oe_o)
    else $error("reset line pulled after power-up");
  a_por_ignores_line: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    en_i && state_q == rbms_pkg::RBMS_POWER_UP && por_cnt_q != 32'(POR_CYCLES - 1)
    |=> state_q == rbms_pkg::RBMS_POWER_UP)
    else $error("power-up interval cut short");
  a_wait_line_low: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    en_i && state_q == rbms_pkg::RBMS_WAIT_HIGH && !line_s2_q |=> !running)
    else $error("run entered while line low");
  a_run_on_high: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    en_i && state_q == rbms_pkg::RBMS_WAIT_HIGH && line_s2_q |=> running)
    else $error("run not entered after line high");
  a_outs_quiet: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    en_i && !running |=> digital_output_o == rbms_pkg::OUT_RESET)
    else $error("output values kept off run");
  a_tx_idle_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    en_i && !running |=> serial_out_o)
    else $error("serial out not idle off run");
  a_mode_clear_por: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    state_q == rbms_pkg::RBMS_POWER_UP |-> !boot_mode_o)
    else $error("boot mode set during power-up");
  a_freeze_state: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !en_i |=> $stable(state_q) && $stable(mode_q) && $stable(out_q))
    else $error("state moved while enable low");
  a_rx_gated: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    en_i && !running |=> !rx_valid_o)
    else $error("byte delivered off run");
  a_oe_all_run: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    running |-> digital_output_oe_o == 8'hFF && serial_out_oe_o)
    else $error("pins floating while running");
  a_ready_busy: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    en_i && tx_valid_i && tx_ready_o |=> !tx_ready_o)
    else $error("ready kept after byte taken");
endmodule : rbms_top

/* File: bench/rbms_host.sv */
// host pc serial end and outside open-drain reset driver
`timescale 1ns/1ps
module rbms_host #(
  parameter int unsigned BIT = 868
) (
  // clock
  input  wire logic       clk_i,
  // serial pins
  input  wire logic       serial_out_i,
  output logic            serial_in_o,
  // open-drain pull on the reset line, low = pulling
  output logic            ext_pull_n_o,
  // bytes decoded from the transmit pin
  output logic      [7:0] got_o,
  output int              got_cnt_o
);
  initial begin
    serial_in_o  = 1'b1;
    ext_pull_n_o = 1'b1;
    got_o        = 8'h00;
    got_cnt_o    = 0;
  end

  // ---------------------------------------------------------------
  // host transmitter, stop level chosen by caller
  // ---------------------------------------------------------------
  task automatic send(input logic [7:0] b, input logic stop);
    logic [9:0] fr;
    fr = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_i);
      #1 serial_in_o = fr[i];
      repeat (BIT - 1) @(posedge clk_i);
    end
    @(posedge clk_i);
    #1 serial_in_o = 1'b1;
  endtask : send

  // ---------------------------------------------------------------
  // outside reset: only pulls low or lets go, never drives high
  // ---------------------------------------------------------------
  task automatic pull_reset(input int n);
    @(posedge clk_i);
    #1 ext_pull_n_o = 1'b0;
    repeat (n) @(posedge clk_i);
    #1 ext_pull_n_o = 1'b1;
  endtask : pull_reset

  // ---------------------------------------------------------------
  // host receiver, samples at bit centres
  // ---------------------------------------------------------------
  always begin : rx
    logic [7:0] sh;
    @(negedge serial_out_i);
    repeat (BIT / 2) @(posedge clk_i);
    if (serial_out_i == 1'b0) begin
      for (int i = 0; i < 8; i++) begin
        repeat (BIT) @(posedge clk_i);
        sh[i] = serial_out_i;
      end
      repeat (BIT) @(posedge clk_i);
      if (serial_out_i == 1'b1) begin
        got_o = sh;
        got_cnt_o++;
      end
    end
  end
endmodule : rbms_host

/* File: bench/tb.sv */
// self-checking bench for the reset sequencer and host serial port
`timescale 1ns/1ps
module tb;
  localparam int unsigned POR = 20;
  localparam int unsigned BIT = rbms_pkg::BAUD_DIV;
  logic        clk_i, rst_n_i, en_i, boot_select_n_i, update_jumper_i, tx_valid_i;
  logic  [7:0] app_out_i, tx_data_i, digital_output_o, digital_output_oe_o, rx_data_o, got;
  logic        reset_line_n_o, reset_line_n_oe_o, serial_in, serial_out_o, serial_out_oe_o;
  logic        tx_ready_o, rx_valid_o, running_o, boot_mode_o, ext_pull_n;
  int          got_cnt, errors, n_compared;
  logic [31:0] seed;
  wire         reset_line_n;
  // open-drain line with pull-up
  assign reset_line_n = ((reset_line_n_oe_o && !reset_line_n_o) || !ext_pull_n) ? 1'b0 : 1'b1;

  rbms_top #(.POR_CYCLES(POR)) dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .en_i(en_i),
    .reset_line_n_i(reset_line_n), .reset_line_n_o(reset_line_n_o),
    .reset_line_n_oe_o(reset_line_n_oe_o), .boot_select_n_i(boot_select_n_i),
    .update_jumper_i(update_jumper_i), .app_out_i(app_out_i),
    .digital_output_o(digital_output_o), .digital_output_oe_o(digital_output_oe_o),
    .serial_in_i(serial_in), .serial_out_o(serial_out_o), .serial_out_oe_o(serial_out_oe_o),
    .tx_data_i(tx_data_i), .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o),
    .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o), .running_o(running_o),
    .boot_mode_o(boot_mode_o));

  rbms_host #(.BIT(BIT)) host (
    .clk_i(clk_i), .serial_out_i(serial_out_o), .serial_in_o(serial_in),
    .ext_pull_n_o(ext_pull_n), .got_o(got), .got_cnt_o(got_cnt));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  function automatic logic [7:0] exp_mode(input logic bsel_n, input logic jmp);
    return {7'h00, !bsel_n || jmp};
  endfunction : exp_mode
  function automatic logic [7:0] ctl();
    return {4'h0, reset_line_n, serial_out_oe_o, reset_line_n_oe_o, running_o};
  endfunction : ctl
  task automatic tick();
    @(posedge clk_i);
    #1;
  endtask : tick
  task automatic results();
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic stall(input string what);
    errors++;
    $display("unexpected %s: expected done seen timeout", what);
    results();
  endtask : stall

  // ---------------------------------------------------------------
  // reset, start-up and strap latching
  // ---------------------------------------------------------------
  task automatic boot(input logic bsel_n, input logic jmp, input logic ext);
    int k;
    boot_select_n_i = bsel_n;
    update_jumper_i = jmp;
    if (ext) begin
      fork
        host.pull_reset(12);
        begin
          repeat (5) tick();
          check("pins ext", 8'h00, digital_output_oe_o);
          check("ctl ext", 8'h00, ctl());
        end
      join
    end else begin
      rst_n_i = 1'b0;
      repeat (20) tick();
      check("pins rst", 8'h00, digital_output_oe_o);
      check("ctl rst", 8'h02, ctl());
      rst_n_i = 1'b1;
      repeat (POR / 2) tick();
      check("ctl por", 8'h02, ctl());
    end
    k = 0;
    while (running_o !== 1'b1) begin
      if (k++ > 100) stall("run");
      tick();
    end
    check("pins run", 8'hFF, digital_output_oe_o);
    check("ctl run", 8'h0D, ctl());
    check("mode", exp_mode(bsel_n, jmp), {7'h00, boot_mode_o});
    boot_select_n_i = ~bsel_n;
    update_jumper_i = ~jmp;
    repeat (4) tick();
    check("mode held", exp_mode(bsel_n, jmp), {7'h00, boot_mode_o});
  endtask : boot

  // ---------------------------------------------------------------
  // serial traffic both ways
  // ---------------------------------------------------------------
  task automatic tx_byte(input logic [7:0] b);
    int k;
    int c0;
    c0 = got_cnt;
    k = 0;
    while (tx_ready_o !== 1'b1) begin
      if (k++ > 1000) stall("tx ready");
      tick();
    end
    tx_data_i = b;
    tx_valid_i = 1'b1;
    tick();
    tx_valid_i = 1'b0;
    check("tx busy", 8'h00, {7'h00, tx_ready_o});
    k = 0;
    while (got_cnt == c0) begin
      if (k++ > 11 * BIT) stall("tx frame");
      tick();
    end
    check("tx byte", b, got);
  endtask : tx_byte
  task automatic rx_byte(input logic [7:0] b, input logic stop);
    logic       hit;
    logic [7:0] d;
    hit = 1'b0;
    d = 8'h00;
    fork
      host.send(b, stop);
      for (int k = 0; k < 10 * BIT; k++) begin
        tick();
        if (rx_valid_o === 1'b1) begin
          hit = 1'b1;
          d = rx_data_o;
        end
      end
    join
    check("rx valid", {7'h00, stop}, {7'h00, hit});
    if (stop) check("rx byte", b, d);
  endtask : rx_byte

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    rst_n_i = 1'b0;
    en_i = 1'b1;
    boot_select_n_i = 1'b1;
    update_jumper_i = 1'b0;
    app_out_i = 8'h00;
    tx_data_i = 8'h00;
    tx_valid_i = 1'b0;
    errors = 0;
    n_compared = 0;
    seed = 32'hD825;
    boot(1'b1, 1'b0, 1'b0);
    $display("test power-up done");
    for (int i = 0; i < 16; i++) begin
      seed = xs(seed);
      app_out_i = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : seed[7:0];
      tick();
      check("output", app_out_i, digital_output_o);
    end
    en_i = 1'b0;
    app_out_i = ~app_out_i;
    tick();
    check("frozen", ~app_out_i, digital_output_o);
    check("ready off", 8'h00, {7'h00, tx_ready_o});
    en_i = 1'b1;
    tick();
    check("thawed", app_out_i, digital_output_o);
    $display("test outputs done");
    seed = xs(seed);
    tx_byte(seed[7:0]);
    tx_byte(8'h80);
    seed = xs(seed);
    rx_byte(seed[7:0], 1'b1);
    rx_byte(8'h01, 1'b1);
    rx_byte(8'hA5, 1'b0);
    $display("test serial done");
    boot(1'b0, 1'b0, 1'b1);
    tx_byte(8'h3C);
    rx_byte(8'hC3, 1'b1);
    $display("test update mode done");
    boot(1'b1, 1'b1, 1'b1);
    boot(1'b1, 1'b0, 1'b1);
    $display("test straps done");
    results();
  end
endmodule : tb
